// [lodc_pkg.sv]
/*
 lodc_pkg: constants, types and register map of the six-channel led output drive control.
 assumes a single core clock; byte-wide register port fed by the serial host interface.
*/
package lodc_pkg;
   localparam int unsigned NUM_CH = 6;
   localparam int unsigned DUTY_W = 4;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 8;

   // register offsets
   localparam logic [7:0] DRIVE_TYPE_OFS = 8'h71;
   localparam logic [7:0] TOUCH_LINK_OFS = 8'h72;
   localparam logic [7:0] POLARITY_OFS   = 8'h73;
   localparam logic [7:0] HOST_ACT_OFS   = 8'h74;

   // field layout: channel n at bit n-1, bits 7..6 unused
   localparam int unsigned CH_LSB = 0;
   localparam int unsigned CH_MSB = 5;

   // reset values
   localparam logic [5:0] DRIVE_TYPE_RST = 6'h00;
   localparam logic [5:0] TOUCH_LINK_RST = 6'h00;
   localparam logic [5:0] POLARITY_RST   = 6'h00;
   localparam logic [5:0] HOST_ACT_RST   = 6'h00;
   localparam logic [5:0] MIRROR_RST     = 6'h00;

   // field values
   localparam logic OPEN_DRAIN   = 1'b0;
   localparam logic PUSH_PULL    = 1'b1;
   localparam logic POL_INVERTED = 1'b0;
   localparam logic POL_NONINV   = 1'b1;

   // breathe ramp direction
   typedef enum logic [1:0] {
      RAMP_UP   = 2'b01,
      RAMP_DOWN = 2'b10
   } lodc_ramp_type;

   // per-channel settings carried to the channel engine
   typedef struct packed {
      logic              drive_type;
      logic              polarity;
      logic              duty_mirror;
      logic              breathe;
      logic              actuate;
      logic [DUTY_W-1:0] min_duty;
      logic [DUTY_W-1:0] max_duty;
   } lodc_chan_cfg_type;

   // pin drive: level and enable
   typedef struct packed {
      logic level;
      logic oe;
   } lodc_pin_type;
endpackage

// [lodc_chan.sv]
/*
 lodc_chan: one led channel: duty selection, breathe ramp, pwm compare and pin drive.
 assumes a shared pwm phase counter and a period-end pulse from the parent.
*/
`timescale 1ns/1ps
module lodc_chan #(
   parameter int unsigned DUTY_W = lodc_pkg::DUTY_W
) (
   input  wire logic                      mclk_in,
   input  wire logic                      arst_n_in,
   input  wire lodc_pkg::lodc_chan_cfg_type cfg_in,
   input  wire logic [DUTY_W-1:0]          phase_in,
   input  wire logic                      period_end_in,
   output      lodc_pkg::lodc_pin_type     pin_out
);
   localparam logic [DUTY_W-1:0] FULL = {DUTY_W{1'b1}};

   lodc_pkg::lodc_ramp_type ramp_dir;
   lodc_pkg::lodc_ramp_type next_ramp_dir;
   logic [DUTY_W-1:0]       ramp;
   logic [DUTY_W-1:0]       next_ramp;

   // settings relative to full scale when mirrored
   wire [DUTY_W-1:0] min_eff = cfg_in.duty_mirror ? FULL - cfg_in.min_duty : cfg_in.min_duty;
   wire [DUTY_W-1:0] max_eff = cfg_in.duty_mirror ? FULL - cfg_in.max_duty : cfg_in.max_duty;

   // not actuated: minimum; direct: maximum; breathe: ramp
   wire [DUTY_W-1:0] duty = !cfg_in.actuate ? min_eff :
                            (cfg_in.breathe ? ramp : max_eff);

   // inverted: duty is low time; non-inverted: duty is high time
   wire on_phase  = phase_in < duty;
   wire level_inv = !on_phase;
   wire level_non = on_phase;
   wire level     = (cfg_in.polarity == lodc_pkg::POL_NONINV) ? level_non : level_inv;

   // breathe ramp runs min to max and back while actuated, or holds at max once reached when min is above max
   always_comb begin
      next_ramp     = ramp;
      next_ramp_dir = ramp_dir;
      if (!cfg_in.actuate || !cfg_in.breathe) begin
         next_ramp     = min_eff;
         next_ramp_dir = lodc_pkg::RAMP_UP;
      end else if (period_end_in) begin
         case (ramp_dir)
            lodc_pkg::RAMP_UP: begin
               if (ramp == max_eff) begin
                  next_ramp_dir = lodc_pkg::RAMP_DOWN;
               end else if (ramp < max_eff) begin
                  next_ramp = ramp + 1'b1;
               end else begin
                  next_ramp = ramp - 1'b1;
               end
            end
            lodc_pkg::RAMP_DOWN: begin
               if (ramp <= min_eff) begin
                  next_ramp_dir = lodc_pkg::RAMP_UP;
               end else begin
                  next_ramp = ramp - 1'b1;
               end
            end
            default: begin
               next_ramp_dir = lodc_pkg::RAMP_UP;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ramp     <= '0;
         ramp_dir <= lodc_pkg::RAMP_UP;
      end else begin
         ramp     <= next_ramp;
         ramp_dir <= next_ramp_dir;
      end
   end

   // open-drain pulls low for level 0, releases for 1; push-pull drives both
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pin_out <= '{level: 1'b0, oe: 1'b0};
      end else if (cfg_in.drive_type == lodc_pkg::PUSH_PULL) begin
         pin_out <= '{level: level, oe: 1'b1};
      end else begin
         pin_out <= '{level: 1'b0, oe: !level};
      end
   end
endmodule // lodc_chan

// [lodc_top.sv]
/*
 lodc_top: led output drive control: four control registers, touch linking, mirror
 tracking and six pwm channel engines driving open-drain or push-pull pins.
 assumes the serial host interface presents byte accesses on one clock, touch flags come
 from the sensor logic on the same clock, and duty/behaviour settings from their registers.
*/
// How it works
// - bit n-1 of each control register serves channel n, channels 1 to 6
// - drive type 0: open-drain, low when active, released when inactive
// - drive type 1: push-pull, drives high for one, low for zero
// - linked channel is actuated by a detected touch on its sensor
// - unlinked channel ignores touches; host bit and behaviour govern it
// - host actuate bit is ignored for a linked channel
// - a linked touch acts exactly like host actuate written to one
// - inverted polarity: actuated value one gives a low pin
// - non-inverted: actuated value one gives high, or released if open-drain
// - polarity writes copy into mirror bits unless mirror blocking is set
// - inverted: duty is low time; unactuated runs at minimum duty
// - inverted breathe ramps low time from minimum up to maximum
// - non-inverted: duty is high time; unactuated runs at full minus minimum
// - non-inverted breathe ramps from full minus minimum to full minus maximum
// - non-inverted direct peak is full minus maximum duty
// - host bit zero gives minimum duty, one gives actuation or maximum
// - mirror bits change duty interpretation only, never the pin directly
// - mirror set: duty settings relative to full scale, else to zero
`timescale 1ns/1ps
module lodc_top #(
   parameter int unsigned NUM_CH = lodc_pkg::NUM_CH,
   parameter int unsigned DUTY_W = lodc_pkg::DUTY_W
) (
   input  wire logic                        mclk_in,
   input  wire logic                        arst_n_in,
   input  wire logic [lodc_pkg::ADDR_W-1:0] reg_addr_in,
   input  wire logic [lodc_pkg::DATA_W-1:0] reg_wdata_in,
   input  wire logic                        reg_wr_in,
   input  wire logic                        reg_rd_in,
   input  wire logic [NUM_CH-1:0]           touch_detect_in,
   input  wire logic                        mirror_follow_block_in,
   input  wire logic [NUM_CH-1:0]           breathe_en_in,
   input  wire logic [NUM_CH*DUTY_W-1:0]    min_duty_in,
   input  wire logic [NUM_CH*DUTY_W-1:0]    max_duty_in,
   output      logic [lodc_pkg::DATA_W-1:0] reg_rdata_out,
   output      logic                        reg_rvalid_out,
   output      logic [NUM_CH-1:0]           chan_duty_mirror_out,
   output      logic [NUM_CH-1:0]           led_pin_out,
   output      logic [NUM_CH-1:0]           led_pin_oe_out
);
   // address match shared by the write and read paths
   function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
      reg_hit = (addr == ofs);
   endfunction

   logic [NUM_CH-1:0]       led_pin_drive_type;
   logic [NUM_CH-1:0]       sensor_to_led_link;
   logic [NUM_CH-1:0]       led_pin_polarity;
   logic [NUM_CH-1:0]       led_host_actuate;
   logic [DUTY_W-1:0]       phase;
   logic [DUTY_W-1:0]       next_phase;
   logic [lodc_pkg::DATA_W-1:0] next_rdata;

   // register decode
   wire hit_type = reg_hit(reg_addr_in, lodc_pkg::DRIVE_TYPE_OFS);
   wire hit_link = reg_hit(reg_addr_in, lodc_pkg::TOUCH_LINK_OFS);
   wire hit_pol  = reg_hit(reg_addr_in, lodc_pkg::POLARITY_OFS);
   wire hit_act  = reg_hit(reg_addr_in, lodc_pkg::HOST_ACT_OFS);
   wire [NUM_CH-1:0] wr_bits = reg_wdata_in[NUM_CH-1:0];

   // actuation source per channel
   wire [NUM_CH-1:0] actuate = (sensor_to_led_link & touch_detect_in)
                             | (~sensor_to_led_link & led_host_actuate);

   // readback, upper bits zero, unmapped reads zero
   wire [NUM_CH-1:0] rd_bits = hit_type ? led_pin_drive_type :
                               hit_link ? sensor_to_led_link :
                               hit_pol  ? led_pin_polarity :
                               hit_act  ? led_host_actuate : '0;
   assign next_rdata = {{(lodc_pkg::DATA_W-NUM_CH){1'b0}}, rd_bits};

   // pwm phase counter shared by all channels
   assign next_phase = phase + 1'b1;
   wire period_end = (phase == {DUTY_W{1'b1}});

   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         phase <= '0;
      end else begin
         phase <= next_phase;
      end
   end

   // control registers
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         led_pin_drive_type <= lodc_pkg::DRIVE_TYPE_RST;
         sensor_to_led_link <= lodc_pkg::TOUCH_LINK_RST;
         led_pin_polarity   <= lodc_pkg::POLARITY_RST;
         led_host_actuate   <= lodc_pkg::HOST_ACT_RST;
      end else if (reg_wr_in) begin
         if (hit_type) begin
            led_pin_drive_type <= wr_bits;
         end
         if (hit_link) begin
            sensor_to_led_link <= wr_bits;
         end
         if (hit_pol) begin
            led_pin_polarity <= wr_bits;
         end
         if (hit_act) begin
            led_host_actuate <= wr_bits;
         end
      end
   end

   // mirror bits track polarity writes unless blocked
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         chan_duty_mirror_out <= lodc_pkg::MIRROR_RST;
      end else if (reg_wr_in && hit_pol && !mirror_follow_block_in) begin
         chan_duty_mirror_out <= wr_bits;
      end
   end

   // read data, registered
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         reg_rdata_out  <= '0;
         reg_rvalid_out <= 1'b0;
      end else begin
         reg_rvalid_out <= reg_rd_in;
         if (reg_rd_in) begin
            reg_rdata_out <= next_rdata;
         end
      end
   end

   // channel engines
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
         lodc_pkg::lodc_chan_cfg_type cfg;
         lodc_pkg::lodc_pin_type      pin;

         // mirror reaches only the duty interpretation
         assign cfg = '{drive_type:  led_pin_drive_type[ch],
                        polarity:    led_pin_polarity[ch],
                        duty_mirror: chan_duty_mirror_out[ch],
                        breathe:     breathe_en_in[ch],
                        actuate:     actuate[ch],
                        min_duty:    min_duty_in[ch*DUTY_W +: DUTY_W],
                        max_duty:    max_duty_in[ch*DUTY_W +: DUTY_W]};

         lodc_chan #(
            .DUTY_W (DUTY_W)
         ) u_chan (
            .mclk_in       (mclk_in),
            .arst_n_in     (arst_n_in),
            .cfg_in        (cfg),
            .phase_in      (phase),
            .period_end_in (period_end),
            .pin_out       (pin)
         );

         assign led_pin_out[ch]    = pin.level;
         assign led_pin_oe_out[ch] = pin.oe;
      end
   endgenerate
endmodule // lodc_top

// [lodc_top_assertions.sv]
/*
 lodc_top_assertions: port-level checker for lodc_top, bound into every instance.
 assumes one clock domain and the register map of lodc_pkg.
*/
`timescale 1ns/1ps
module lodc_top_assertions #(
   parameter int unsigned NUM_CH = lodc_pkg::NUM_CH
) (
   input wire logic                        mclk_in,
   input wire logic                        arst_n_in,
   input wire logic [lodc_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic [lodc_pkg::DATA_W-1:0] reg_wdata_in,
   input wire logic                        reg_wr_in,
   input wire logic                        reg_rd_in,
   input wire logic                        mirror_follow_block_in,
   input wire logic [lodc_pkg::DATA_W-1:0] reg_rdata_out,
   input wire logic                        reg_rvalid_out,
   input wire logic [NUM_CH-1:0]           chan_duty_mirror_out,
   input wire logic [NUM_CH-1:0]           led_pin_out,
   input wire logic [NUM_CH-1:0]           led_pin_oe_out
);
   logic [NUM_CH-1:0] shadow [4];
   wire  [1:0]        sel    = reg_addr_in[1:0] - 2'h1;
   wire               mapped = reg_addr_in >= lodc_pkg::DRIVE_TYPE_OFS &&
                               reg_addr_in <= lodc_pkg::HOST_ACT_OFS;
   wire  [7:0]        exp_rd = mapped ? 8'(shadow[sel]) : 8'h00;
   wire               pol_wr = reg_wr_in && reg_addr_in == lodc_pkg::POLARITY_OFS &&
                               !mirror_follow_block_in;
   // register shadow fed by host writes
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         shadow <= '{default: '0};
      end else if (reg_wr_in && mapped) begin
         shadow[sel] <= reg_wdata_in[NUM_CH-1:0];
      end
   end
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!arst_n_in);
   a_read_answer: assert property (reg_rd_in |=> reg_rvalid_out)
      else $error("read not answered after one cycle");
   a_no_stray_rvalid: assert property (!reg_rd_in |=> !reg_rvalid_out)
      else $error("read valid without read");
   a_rdata_match: assert property (reg_rd_in |=> reg_rdata_out == $past(exp_rd))
      else $error("read data differs from written value");
   a_upper_zero: assert property (reg_rvalid_out |-> reg_rdata_out[7:6] == 2'h0)
      else $error("unused read bits not zero");
   a_mirror_follow: assert property (pol_wr |=>
      chan_duty_mirror_out == NUM_CH'($past(reg_wdata_in)))
      else $error("mirror did not follow polarity write");
   a_mirror_hold: assert property (!pol_wr |=> $stable(chan_duty_mirror_out))
      else $error("mirror changed without polarity write");
   a_od_released: assert property ((led_pin_out & ~shadow[0] & ~$past(shadow[0])) == '0)
      else $error("open-drain pin driven high");
   a_pp_driven: assert property ((~led_pin_oe_out & shadow[0] & $past(shadow[0])) == '0)
      else $error("push-pull pin not driven");
endmodule // lodc_top_assertions

bind lodc_top lodc_top_assertions #(.NUM_CH(NUM_CH)) chk_u (.mclk_in, .arst_n_in,
   .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .mirror_follow_block_in,
   .reg_rdata_out, .reg_rvalid_out, .chan_duty_mirror_out, .led_pin_out, .led_pin_oe_out);

// [lodc_led_model.sv]
/*
 lodc_led_model: six leds with pull-up resistors on the pin side.
 assumes pin level and enable from lodc_top; a released pin floats to the pull-up.
*/
`timescale 1ns/1ps
module lodc_led_model (
   input  wire logic [5:0] pin_in,
   input  wire logic [5:0] pin_oe_in,
   output      logic [5:0] level_out
);
   // pull-up wins where nothing drives
   assign level_out = (pin_oe_in & pin_in) | ~pin_oe_in;
endmodule // lodc_led_model

// [test_led_output_drive_control.sv]
/*
 test_led_output_drive_control: self-checking bench for lodc_top.
 assumes the pull-up led model on the pins; low time counted over one pwm period, or six periods for breathe.
*/
`timescale 1ns/1ps
module test_led_output_drive_control;
   logic        mclk_in = 1'b0;
   logic        arst_n_in = 1'b0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        blk = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [7:0]  wdata = 8'h00;
   logic [5:0]  touch = 6'h00;
   logic [5:0]  brth = 6'h00;
   logic [23:0] mind = {6{4'h2}};
   logic [23:0] maxd = {6{4'h4}};
   logic [7:0]  rdata;
   logic        rvalid;
   logic [5:0]  mir, pin, oe, lvl;
   int          error_cnt = 0;
   int          num_checks = 0;
   always #5 mclk_in = ~mclk_in;
   lodc_top dut_u (.mclk_in, .arst_n_in, .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .touch_detect_in(touch), .mirror_follow_block_in(blk),
      .breathe_en_in(brth), .min_duty_in(mind), .max_duty_in(maxd), .reg_rdata_out(rdata),
      .reg_rvalid_out(rvalid), .chan_duty_mirror_out(mir), .led_pin_out(pin),
      .led_pin_oe_out(oe));
   lodc_led_model led_u (.pin_in(pin), .pin_oe_in(oe), .level_out(lvl));
   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", name, exp, got);
         error_cnt++;
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk_in);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk_in);
      rd <= 1'b0;
      @(negedge mclk_in);
      check("rvalid", 8'h01, {7'h00, rvalid});
      check("rdata", exp, rdata);
   endtask
   // low cycles of every pin over len cycles, returns on a rising edge
   task automatic duty(input logic [7:0] exp, input int len = 16);
      logic [7:0] cnt [6];
      repeat (3) @(posedge mclk_in);
      cnt = '{default: 8'h00};
      repeat (len) begin
         @(negedge mclk_in);
         for (int c = 0; c < 6; c++) cnt[c] += {7'h00, !lvl[c]};
      end
      for (int c = 0; c < 6; c++) check("low count", exp, cnt[c]);
      @(posedge mclk_in);
   endtask
   task automatic test_regs;
      for (int i = 0; i < 4; i++) begin
         rd_reg(8'h71 + 8'(i), 8'h00);
         wr_reg(8'h71 + 8'(i), 8'hFF);
         rd_reg(8'h71 + 8'(i), 8'h3F);
         wr_reg(8'h71 + 8'(i), 8'h00);
      end
      wr_reg(8'h75, 8'hFF);
      rd_reg(8'h75, 8'h00);
      rd_reg(8'h70, 8'h00);
      $display("done registers");
   endtask
   task automatic test_drive;
      for (int t = 0; t < 2; t++) begin
         wr_reg(8'h71, t ? 8'h2A : 8'h15);
         duty(8'h02);
         wr_reg(8'h74, 8'h3F);
         duty(8'h04);
         blk <= 1'b1;
         wr_reg(8'h73, 8'h3F);
         duty(8'h0C);
         wr_reg(8'h74, 8'h00);
         duty(8'h0E);
         wr_reg(8'h73, 8'h00);
         blk <= 1'b0;
      end
      $display("done drive");
   endtask
   task automatic test_link;
      wr_reg(8'h74, 8'h3F);
      wr_reg(8'h72, 8'h3F);
      duty(8'h02);
      touch <= 6'h3F;
      duty(8'h04);
      wr_reg(8'h72, 8'h00);
      wr_reg(8'h74, 8'h00);
      duty(8'h02);
      touch <= 6'h00;
      $display("done link");
   endtask
   // one breathe cycle is six periods: 2,3,4,4,3,2 low cycles when inverted
   task automatic test_breathe;
      wr_reg(8'h74, 8'h3F);
      brth <= 6'h3F;
      duty(8'h12, 96);
      blk <= 1'b1;
      wr_reg(8'h73, 8'h3F);
      duty(8'h4E, 96);
      wr_reg(8'h73, 8'h00);
      blk <= 1'b0;
      brth <= 6'h00;
      wr_reg(8'h74, 8'h00);
      $display("done breathe");
   endtask
   task automatic test_mirror;
      wr_reg(8'h73, 8'h15);
      @(negedge mclk_in);
      check("mirror", 8'h15, {2'h0, mir});
      wr_reg(8'h73, 8'h3F);
      duty(8'h03);
      check("mirror", 8'h3F, {2'h0, mir});
      blk <= 1'b1;
      wr_reg(8'h73, 8'h2A);
      @(negedge mclk_in);
      check("mirror", 8'h3F, {2'h0, mir});
      @(posedge mclk_in);
      blk <= 1'b0;
      wr_reg(8'h73, 8'h00);
      @(negedge mclk_in);
      check("mirror", 8'h00, {2'h0, mir});
      $display("done mirror");
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge mclk_in);
      arst_n_in <= 1'b1;
      test_regs();
      test_drive();
      test_link();
      test_breathe();
      test_mirror();
      complete_run();
   end
endmodule // test_led_output_drive_control
